// ===== design/fsb_arb_pkg.sv
package fsb_arb_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] MASK_OFS   = 8'h08;
  localparam logic [7:0] BPM_OFS    = 8'h0c;
  localparam logic [7:0] CFG_OFS    = 8'h10;
  localparam logic [7:0] ISSUE_OFS  = 8'h14;
  localparam logic [7:0] QUEUE_OFS  = 8'h18;

  // Control fields
  localparam int CTRL_NEED_BIT  = 0;
  localparam int CTRL_LOCK_BIT  = 1;
  localparam int CTRL_STALL_BIT = 2;
  localparam int CTRL_ERR_BIT   = 3;
  localparam int CTRL_RDY_BIT   = 4;
  localparam int CTRL_W         = 5;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // Status and mask fields
  localparam int ST_BUS_INIT_N_BIT = 0;
  localparam int ST_PROBE_REQUEST_N_BIT  = 1;
  localparam int ST_PRIORITY_BUS_REQ_N_BIT  = 2;
  localparam int ST_BNR_BIT   = 3;
  localparam int ST_DONE_BIT  = 4;
  localparam int ST_W         = 5;
  localparam logic [4:0] ST_RST   = 5'h00;
  localparam logic [4:0] MASK_RST = 5'h00;

  // Breakpoint monitor lines
  localparam int BPM_W       = 6;
  localparam int BPM_STAT_W  = 4;
  localparam int BPM_RDY_BIT = 4;
  localparam int BPM_REQ_BIT = 5;
  localparam logic [3:0] BPM_RST = 4'h0;

  // Config readback fields
  localparam int CFG_DRV_BIT   = 0;
  localparam int CFG_OBS_BIT   = 1;
  localparam int CFG_ID_BIT    = 2;
  localparam int CFG_BSEL_LSB  = 4;
  localparam int CFG_STATE_LSB = 8;
  localparam int CFG_OWN_BIT   = 10;

  // 400 MT/s from a 100 MHz bus clock
  localparam logic [1:0] BSEL_100MHZ = 2'h0;

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_REQ,
    ARB_OWN
  } arb_state_t;

endpackage

// ===== design/arb_if.sv
interface arb_if;
  logic                    need;
  logic                    locked;
  logic                    priority_bus_req_n_act;
  logic                    bnr_act;
  logic                    bus_init_n_rst;
  logic                    br_req;
  logic                    issue_ok;
  fsb_arb_pkg::arb_state_t state;

  modport ctl (
    output need, locked, priority_bus_req_n_act, bnr_act, bus_init_n_rst,
    input  br_req, issue_ok, state
  );
  modport arb (
    input  need, locked, priority_bus_req_n_act, bnr_act, bus_init_n_rst,
    output br_req, issue_ok, state
  );
endinterface

// ===== design/bus_req_arb.sv
module bus_req_arb (
  input  wire logic clk_i,
  input  wire logic rst_i,
  arb_if.arb        a
);

  fsb_arb_pkg::arb_state_t state_r;
  fsb_arb_pkg::arb_state_t state_nxt;
  logic                    blocked;

  // Priority agent holds off new requests unless a lock is in progress
  assign blocked = a.priority_bus_req_n_act && !a.locked;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fsb_arb_pkg::ARB_IDLE: begin
        if (a.need) begin
          state_nxt = fsb_arb_pkg::ARB_REQ;
        end
      end
      fsb_arb_pkg::ARB_REQ: begin
        if (!a.need) begin
          state_nxt = fsb_arb_pkg::ARB_IDLE;
        end else if (!blocked) begin
          state_nxt = fsb_arb_pkg::ARB_OWN;
        end
      end
      fsb_arb_pkg::ARB_OWN: begin
        if (!a.need) begin
          state_nxt = fsb_arb_pkg::ARB_IDLE;
        end else if (blocked) begin
          state_nxt = fsb_arb_pkg::ARB_REQ;
        end
      end
      default: state_nxt = fsb_arb_pkg::ARB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || a.bus_init_n_rst) begin
      state_r <= fsb_arb_pkg::ARB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign a.state    = state_r;
  assign a.br_req   = (state_r != fsb_arb_pkg::ARB_IDLE);
  // No new transaction during a stall or a priority hold
  assign a.issue_ok = (state_r == fsb_arb_pkg::ARB_OWN) &&
                      !a.bnr_act && !blocked;

endmodule

// ===== design/fsb_arbitration_control.sv
module fsb_arbitration_control #(
  parameter int          IOQ_DEPTH = 8,
  parameter int          PEND_MAX  = 15,
  parameter logic [1:0]  BSEL_CODE = fsb_arb_pkg::BSEL_100MHZ
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq_o,
  input  wire logic        cfg_bus_init_n_drv_en_i,
  input  wire logic        cfg_bus_init_n_obs_en_i,
  input  wire logic        bus_init_n_i,
  output logic             bus_init_n_o,
  output logic             bus_init_oe_n_o,
  input  wire logic        block_next_req_n_i,
  output logic             block_next_req_n_o,
  output logic             block_next_req_oe_n_o,
  input  wire logic        priority_bus_req_n_i,
  input  wire logic        symmetric_bus_req_n_i,
  output logic             symmetric_bus_req_n_o,
  output logic             symmetric_bus_req_oe_n_o,
  input  wire logic [5:0]  breakpoint_monitor_n_i,
  output logic      [5:0]  breakpoint_monitor_n_o,
  output logic      [5:0]  breakpoint_monitor_oe_n_o,
  output logic      [1:0]  bus_clock_select_o,
  input  wire logic        txn_done_i,
  output logic             txn_issue_o
);

  localparam int QW = 8;

  arb_if arb ();

  logic [fsb_arb_pkg::CTRL_W-1:0] ctrl_r;
  logic [fsb_arb_pkg::ST_W-1:0]   stat_r;
  logic [fsb_arb_pkg::ST_W-1:0]   mask_r;
  logic [fsb_arb_pkg::ST_W-1:0]   ev;
  logic [fsb_arb_pkg::BPM_STAT_W-1:0] bpm_r;
  logic [fsb_arb_pkg::BPM_W-1:0]  bpm_n_nxt;
  logic [fsb_arb_pkg::BPM_W-1:0]  bpm_oe_n_nxt;
  logic [QW-1:0]                  pend_r;
  logic [QW-1:0]                  ioq_r;
  logic                           cfg_done_r;
  logic                           drv_en_r;
  logic                           obs_en_r;
  logic                           agent_id_r;
  logic                           err_r;
  logic                           bus_init_n_seen;
  logic                           wr_stb;
  logic                           rd_stb;
  logic                           issue;
  logic                           add_pend;
  logic                           ioq_full;
  logic [31:0]                    rd_data;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [QW-1:0] cnt_step(input logic [QW-1:0] c,
                                             input logic up,
                                             input logic dn);
    cnt_step = c;
    if (up && !dn) begin
      cnt_step = c + 8'h01;
    end else if (dn && !up) begin
      cnt_step = c - 8'h01;
    end
  endfunction

  // Registered answer: ack in the cycle after the request, dropped next
  assign wr_stb = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign rd_stb = cyc_i && stb_i && !ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Straps caught on the first edge after reset release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_done_r <= 1'b0;
      drv_en_r   <= 1'b0;
      obs_en_r   <= 1'b0;
      agent_id_r <= 1'b0;
    end else if (!cfg_done_r) begin
      cfg_done_r <= 1'b1;
      drv_en_r   <= cfg_bus_init_n_drv_en_i;
      obs_en_r   <= cfg_bus_init_n_obs_en_i;
      agent_id_r <= symmetric_bus_req_n_i;
    end
  end

  assign bus_init_n_seen = cfg_done_r && obs_en_r && !bus_init_n_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= fsb_arb_pkg::CTRL_RST;
    end else begin
      if (wr_stb && hit(adr_i, fsb_arb_pkg::CTRL_OFS)) begin
        ctrl_r <= dat_i[fsb_arb_pkg::CTRL_W-1:0];
      end
      if (bus_init_n_seen) begin
        ctrl_r[fsb_arb_pkg::CTRL_LOCK_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= fsb_arb_pkg::MASK_RST;
      bpm_r  <= fsb_arb_pkg::BPM_RST;
    end else if (wr_stb) begin
      if (hit(adr_i, fsb_arb_pkg::MASK_OFS)) begin
        mask_r <= dat_i[fsb_arb_pkg::ST_W-1:0];
      end
      if (hit(adr_i, fsb_arb_pkg::BPM_OFS)) begin
        bpm_r <= dat_i[fsb_arb_pkg::BPM_STAT_W-1:0];
      end
    end
  end

  // Events; set wins over a write-one clear in the same cycle
  always_comb begin
    ev = '0;
    ev[fsb_arb_pkg::ST_BUS_INIT_N_BIT] = bus_init_n_seen;
    ev[fsb_arb_pkg::ST_PROBE_REQUEST_N_BIT]  =
      !breakpoint_monitor_n_i[fsb_arb_pkg::BPM_REQ_BIT];
    ev[fsb_arb_pkg::ST_PRIORITY_BUS_REQ_N_BIT]  = !priority_bus_req_n_i;
    ev[fsb_arb_pkg::ST_BNR_BIT]   = !block_next_req_n_i;
    ev[fsb_arb_pkg::ST_DONE_BIT]  = txn_done_i && (ioq_r != '0);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= fsb_arb_pkg::ST_RST;
    end else if (wr_stb && hit(adr_i, fsb_arb_pkg::STAT_OFS)) begin
      stat_r <= (stat_r & ~dat_i[fsb_arb_pkg::ST_W-1:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat_r & mask_r);
    end
  end

  // Pending bus queue and in-order queue
  assign add_pend = wr_stb && hit(adr_i, fsb_arb_pkg::ISSUE_OFS) &&
                    (pend_r != QW'(PEND_MAX));
  assign ioq_full = (ioq_r == QW'(IOQ_DEPTH));
  assign issue    = arb.issue_ok && (pend_r != '0) && !ioq_full;

  // Pending entries survive bus-init so they are retried afterwards
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= '0;
    end else begin
      pend_r <= cnt_step(pend_r, add_pend, issue);
    end
  end

  // Queue contents are not cleared by bus-init, only by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ioq_r <= '0;
    end else begin
      ioq_r <= cnt_step(ioq_r, issue,
                        txn_done_i && (ioq_r != '0));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txn_issue_o <= 1'b0;
    end else begin
      txn_issue_o <= issue;
    end
  end

  // Completion without an outstanding entry is a fatal bus condition
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_r <= 1'b0;
    end else if (txn_done_i && (ioq_r == '0)) begin
      err_r <= 1'b1;
    end else if (wr_stb && hit(adr_i, fsb_arb_pkg::CTRL_OFS) &&
                 !dat_i[fsb_arb_pkg::CTRL_ERR_BIT]) begin
      err_r <= 1'b0;
    end
  end

  assign arb.need      = (pend_r != '0) ||
                         ctrl_r[fsb_arb_pkg::CTRL_NEED_BIT];
  assign arb.locked    = ctrl_r[fsb_arb_pkg::CTRL_LOCK_BIT];
  assign arb.priority_bus_req_n_act  = !priority_bus_req_n_i;
  assign arb.bnr_act   = !block_next_req_n_i;
  assign arb.bus_init_n_rst = bus_init_n_seen;

  bus_req_arb u_arb (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .a     (arb.arb)
  );

  // Pin drivers; enables are active low, pins released in reset
  always_ff @(posedge clk_i) begin
    if (rst_i || !cfg_done_r) begin
      symmetric_bus_req_n_o    <= 1'b1;
      symmetric_bus_req_oe_n_o <= 1'b1;
    end else begin
      symmetric_bus_req_n_o    <= !arb.br_req;
      symmetric_bus_req_oe_n_o <= 1'b0;
    end
  end

  // Open-drain style: drive low only while asserting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_init_n_o    <= 1'b1;
      bus_init_oe_n_o <= 1'b1;
    end else begin
      bus_init_n_o    <= 1'b0;
      bus_init_oe_n_o <= !(drv_en_r &&
        (err_r || ctrl_r[fsb_arb_pkg::CTRL_ERR_BIT]));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_next_req_n_o    <= 1'b1;
      block_next_req_oe_n_o <= 1'b1;
    end else begin
      block_next_req_n_o    <= 1'b0;
      block_next_req_oe_n_o <= !(ioq_full ||
        ctrl_r[fsb_arb_pkg::CTRL_STALL_BIT]);
    end
  end

  // Probe request line stays an input; all others are driven
  always_comb begin
    bpm_n_nxt    = '1;
    bpm_oe_n_nxt = '0;
    bpm_n_nxt[fsb_arb_pkg::BPM_STAT_W-1:0] = ~bpm_r;
    bpm_n_nxt[fsb_arb_pkg::BPM_RDY_BIT] =
      !ctrl_r[fsb_arb_pkg::CTRL_RDY_BIT];
    // Left to the debug tool, which pulls it low to ask for debug
    bpm_oe_n_nxt[fsb_arb_pkg::BPM_REQ_BIT] = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      breakpoint_monitor_n_o    <= '1;
      breakpoint_monitor_oe_n_o <= '1;
    end else begin
      breakpoint_monitor_n_o    <= bpm_n_nxt;
      breakpoint_monitor_oe_n_o <= bpm_oe_n_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_clock_select_o <= fsb_arb_pkg::BSEL_100MHZ;
    end else begin
      bus_clock_select_o <= BSEL_CODE;
    end
  end

  always_comb begin
    rd_data = '0;
    case (adr_i)
      fsb_arb_pkg::CTRL_OFS: begin
        rd_data[fsb_arb_pkg::CTRL_W-1:0] = ctrl_r;
      end
      fsb_arb_pkg::STAT_OFS: begin
        rd_data[fsb_arb_pkg::ST_W-1:0] = stat_r;
      end
      fsb_arb_pkg::MASK_OFS: begin
        rd_data[fsb_arb_pkg::ST_W-1:0] = mask_r;
      end
      fsb_arb_pkg::BPM_OFS: begin
        rd_data[fsb_arb_pkg::BPM_W-1:0] = ~breakpoint_monitor_n_i;
      end
      fsb_arb_pkg::CFG_OFS: begin
        rd_data[fsb_arb_pkg::CFG_DRV_BIT] = drv_en_r;
        rd_data[fsb_arb_pkg::CFG_OBS_BIT] = obs_en_r;
        rd_data[fsb_arb_pkg::CFG_ID_BIT]  = agent_id_r;
        rd_data[fsb_arb_pkg::CFG_BSEL_LSB +: 2] = bus_clock_select_o;
        rd_data[fsb_arb_pkg::CFG_STATE_LSB +: 2] = arb.state;
        rd_data[fsb_arb_pkg::CFG_OWN_BIT] = arb.issue_ok;
      end
      fsb_arb_pkg::QUEUE_OFS: begin
        rd_data[QW-1:0]  = pend_r;
        rd_data[15:8]    = ioq_r;
      end
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (rd_stb) begin
      dat_o <= rd_data;
    end
  end

endmodule

// ===== sim/fsb_arb_checker.sv
module fsb_arb_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       cfg_bus_init_n_drv_en_i,
  input wire logic       block_next_req_n_i,
  input wire logic       bus_init_n_o,
  input wire logic       bus_init_oe_n_o,
  input wire logic       block_next_req_n_o,
  input wire logic       block_next_req_oe_n_o,
  input wire logic [5:0] breakpoint_monitor_oe_n_o,
  input wire logic [1:0] bus_clock_select_o,
  input wire logic       txn_issue_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up_r;
  logic       drv_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Pins settle two edges after reset; straps latch on the first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_i && up_r == 2'h0) begin
      drv_r <= cfg_bus_init_n_drv_en_i;
    end
  end
  property p_ack_once; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("request not acked after one cycle");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_bsel;
    up_r == 2'h3 |-> bus_clock_select_o == fsb_arb_pkg::BSEL_100MHZ;
  endproperty
  a_bsel: assert property (p_bsel)
    else $error("wrong bus select code");
  property p_bpm_oe; up_r == 2'h3 |-> breakpoint_monitor_oe_n_o == 6'h20;
  endproperty
  a_bpm_oe: assert property (p_bpm_oe)
    else $error("monitor line enables wrong");
  property p_bus_init_n_low; !bus_init_oe_n_o |-> !bus_init_n_o; endproperty
  a_bus_init_n_low: assert property (p_bus_init_n_low)
    else $error("bus-init driven high");
  property p_bus_init_n_off; up_r == 2'h3 && !drv_r |-> bus_init_oe_n_o;
  endproperty
  a_bus_init_n_off: assert property (p_bus_init_n_off)
    else $error("bus-init driven with driver disabled");
  property p_bnr_low; !block_next_req_oe_n_o |-> !block_next_req_n_o;
  endproperty
  a_bnr_low: assert property (p_bnr_low)
    else $error("stall line driven high");
  property p_bnr_block; !block_next_req_n_i [*3] |-> !txn_issue_o;
  endproperty
  a_bnr_block: assert property (p_bnr_block)
    else $error("issue during stall");
endmodule

bind fsb_arbitration_control fsb_arb_checker u_fsb_arb_checker (.*);

// ===== sim/fsb_agent_model.sv
module fsb_agent_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  input  wire logic stall_i,
  input  wire logic prio_i,
  input  wire logic fault_i,
  input  wire logic probe_i,
  input  wire logic txn_issue_i,
  output logic      txn_done_o = 1'b0,
  output logic      stall_n_o,
  output logic      prio_n_o,
  output logic      fault_n_o,
  output logic      probe_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int outst = 0;
  int wait_c = 0;
  assign stall_n_o = !stall_i;
  assign prio_n_o = !prio_i;
  assign fault_n_o = !fault_i;
  assign probe_n_o = !probe_i;
  // Retires in order; slow mode makes the design wait on completion
  always @(posedge clk_i) begin
    txn_done_o <= 1'b0;
    if (rst_i) begin
      outst = 0;
    end else begin
      outst += int'(txn_issue_i === 1'b1);
      wait_c = (outst > 0) ? wait_c + 1 : 0;
      if (wait_c > (slow_i ? 4 : 1)) begin
        txn_done_o <= 1'b1;
        outst--;
        wait_c = 0;
      end
    end
  end
endmodule

// ===== sim/fsb_arbitration_control_test.sv
module fsb_arbitration_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ST = fsb_arb_pkg::STAT_OFS;
  localparam logic [7:0] MK = fsb_arb_pkg::MASK_OFS;
  localparam logic [7:0] IS = fsb_arb_pkg::ISSUE_OFS;
  localparam logic [7:0] QU = fsb_arb_pkg::QUEUE_OFS;
  localparam logic [7:0] CT = fsb_arb_pkg::CTRL_OFS;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0000_0000;
  logic        cfg_bus_init_n_drv_en_i = 1'b1, cfg_bus_init_n_obs_en_i = 1'b1;
  logic        slow = 1'b0, stall = 1'b0, prio = 1'b0, fault = 1'b0;
  logic        probe = 1'b0, strap_n = 1'b0, stall_n, fault_n, probe_n;
  logic        ack_o, irq_o, txn_done_i, txn_issue_o, bus_init_n_i;
  logic        bus_init_n_o, bus_init_oe_n_o, block_next_req_n_i;
  logic        block_next_req_n_o, block_next_req_oe_n_o;
  logic        priority_bus_req_n_i, symmetric_bus_req_n_i;
  logic        symmetric_bus_req_n_o, symmetric_bus_req_oe_n_o;
  logic [5:0]  breakpoint_monitor_n_i, breakpoint_monitor_n_o;
  logic [5:0]  breakpoint_monitor_oe_n_o;
  logic [1:0]  bus_clock_select_o;
  logic [31:0] dat_o;
  logic [15:0] q;
  int          fails = 0, n_compared = 0, n_iss = 0, n_done = 0, n_req = 0;

  fsb_arbitration_control u_fsb_arbitration_control (.*);
  fsb_agent_model u_fsb_agent_model (
    .clk_i, .rst_i, .slow_i(slow), .stall_i(stall), .prio_i(prio),
    .fault_i(fault), .probe_i(probe), .txn_issue_i(txn_issue_o),
    .txn_done_o(txn_done_i), .stall_n_o(stall_n),
    .prio_n_o(priority_bus_req_n_i), .fault_n_o(fault_n),
    .probe_n_o(probe_n)
  );
  // Pulled-up shared lines: any party driving low wins
  assign bus_init_n_i = fault_n & (bus_init_oe_n_o | bus_init_n_o);
  assign block_next_req_n_i =
    stall_n & (block_next_req_oe_n_o | block_next_req_n_o);
  assign symmetric_bus_req_n_i =
    strap_n & (symmetric_bus_req_oe_n_o | symmetric_bus_req_n_o);
  assign breakpoint_monitor_n_i = {probe_n, 5'h1f} &
    (breakpoint_monitor_oe_n_o | breakpoint_monitor_n_o);

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n_iss += int'(txn_issue_o === 1'b1);
    n_done += int'(txn_done_i === 1'b1);
    n_req += int'(strap_n && symmetric_bus_req_n_i === 1'b0);
  end

  task automatic chk(input logic [15:0] g, e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic w,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
    fails += int'(n == 20);
    q = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    acc(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] m, e);
    acc(a, 1'b0, 16'h0000);
    chk(q & m, e);
  endtask
  task automatic wait_done(input int k);
    int n;
    n = 0;
    while (n_done < k && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk(16'(n_done), 16'(k));
  endtask
  task automatic pulse_fault;
    @(posedge clk_i);
    fault <= 1'b1;
    @(posedge clk_i);
    fault <= 1'b0;
  endtask
  task automatic irq_is(input logic [15:0] e);
    @(posedge clk_i);
    chk(16'(irq_o), e);
  endtask
  task automatic oe_is(input logic [15:0] e);
    repeat (2) @(posedge clk_i);
    chk(16'({bus_init_oe_n_o, block_next_req_oe_n_o}), e);
  endtask
  task automatic do_reset;
    rst_i <= 1'b1;
    strap_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    strap_n <= 1'b1;
  endtask
  task automatic done_t(input int t);
    $display("test %0d done", t);
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    rdc(fsb_arb_pkg::CFG_OFS, 16'h0337, 16'h0003);
    rdc(ST, 16'hffff, 16'h0000);
    rdc(8'h1c, 16'hffff, 16'h0000);
    done_t(1);
    wr(IS, 16'h0001);
    wait_done(1);
    chk(16'(n_req > 0), 16'h0001);
    rdc(ST, 16'h0010, 16'h0010);
    wr(CT, 16'h0001);
    rdc(fsb_arb_pkg::CFG_OFS, 16'h0700, 16'h0600);
    wr(CT, 16'h0000);
    done_t(2);
    for (int k = 0; k < 2; k++) begin
      stall <= (k == 0);
      prio <= (k == 1);
      slow <= k[0];
      wr(IS, 16'h0001);
      repeat (8) @(posedge clk_i);
      chk(16'(n_iss), 16'(k + 1));
      rdc(QU, 16'h00ff, 16'h0001);
      rdc(ST, 16'h0008 >> k, 16'h0008 >> k);
      stall <= 1'b0;
      prio <= 1'b0;
      wait_done(k + 2);
    end
    done_t(3);
    stall <= 1'b1;
    wr(ST, 16'h001f);
    wr(IS, 16'h0001);
    pulse_fault();
    rdc(ST, 16'h0001, 16'h0001);
    rdc(QU, 16'h00ff, 16'h0001);
    stall <= 1'b0;
    wait_done(4);
    done_t(4);
    wr(ST, 16'h001f);
    rdc(ST, 16'h001f, 16'h0000);
    wr(MK, 16'h0001);
    pulse_fault();
    rdc(ST, 16'h0001, 16'h0001);
    chk(16'(irq_o), 16'h0001);
    wr(MK, 16'h0000);
    irq_is(16'h0000);
    wr(MK, 16'h0001);
    irq_is(16'h0001);
    wr(ST, 16'h0001);
    irq_is(16'h0000);
    done_t(5);
    wr(fsb_arb_pkg::BPM_OFS, 16'h0005);
    wr(CT, 16'h0010);
    rdc(fsb_arb_pkg::BPM_OFS, 16'h003f, 16'h0015);
    chk(16'(breakpoint_monitor_n_o), 16'h002a);
    probe <= 1'b1;
    rdc(ST, 16'h0002, 16'h0002);
    rdc(fsb_arb_pkg::BPM_OFS, 16'h003f, 16'h0035);
    probe <= 1'b0;
    done_t(6);
    wr(CT, 16'h000c);
    oe_is(16'h0000);
    wr(CT, 16'h0000);
    oe_is(16'h0003);
    done_t(7);
    prio <= 1'b1;
    wr(CT, 16'h0002);
    wr(IS, 16'h0001);
    pulse_fault();
    rdc(QU, 16'hff00, 16'h0100);
    rdc(CT, 16'h0002, 16'h0000);
    wait_done(5);
    wr(IS, 16'h0001);
    repeat (8) @(posedge clk_i);
    chk(16'(n_iss), 16'h0005);
    rdc(fsb_arb_pkg::CFG_OFS, 16'h0700, 16'h0100);
    prio <= 1'b0;
    wait_done(6);
    done_t(8);
    cfg_bus_init_n_drv_en_i <= 1'b0;
    cfg_bus_init_n_obs_en_i <= 1'b0;
    do_reset();
    cfg_bus_init_n_drv_en_i <= 1'b1;
    cfg_bus_init_n_obs_en_i <= 1'b1;
    rdc(fsb_arb_pkg::CFG_OFS, 16'h0007, 16'h0000);
    wr(CT, 16'h0008);
    pulse_fault();
    rdc(ST, 16'h0001, 16'h0000);
    chk(16'(bus_init_oe_n_o), 16'h0001);
    done_t(9);
    finish_test();
  end

  initial begin
    repeat (2000) @(posedge clk_i);
    fails++;
    finish_test();
  end
endmodule
